// *** core/thermo_map.svh ***
// register codes, reset values, strap address bases and timing figures of the status/config block
`ifndef THERMO_MAP_SVH
`define THERMO_MAP_SVH
// ------------------------------------------------------------
// command codes served here
// ------------------------------------------------------------
`define CMD_STATUS1   8'h05
`define CMD_STATUS2   8'h06
`define CMD_CFG_RD    8'h07
`define CMD_CFG_WR    8'h12
`define CMD_MAKER     8'hFE
`define CMD_PART      8'hFF
// ------------------------------------------------------------
// reset values and fixed patterns
// ------------------------------------------------------------
`define CFG_RESET     8'h00
`define BYTE_ZERO     8'h00
`define COLLIDE_LOW7  7'h7F
`define ARA_ADDR      7'h0C
// ------------------------------------------------------------
// strap address bases (prefix plus second strap index)
// ------------------------------------------------------------
`define ADDR_BASE_GND 7'h18
`define ADDR_BASE_FLT 7'h29
`define ADDR_BASE_VCC 7'h4C
`define STRAP_SETTLE  2'h2
// ------------------------------------------------------------
// timing: clock rate and conversion period
// ------------------------------------------------------------
`define CLK_KHZ        10000
`define CONV_PERIOD_MS 333
`define CONV_PERIOD_CY (`CONV_PERIOD_MS * `CLK_KHZ)
`endif

// *** core/thermo_pkg.sv ***
// types shared by the status/config block
package thermo_pkg;
  // ------------------------------------------------------------
  // configuration byte layout
  // ------------------------------------------------------------
  typedef struct packed {
    logic       global_alert_mask;  // bit 7
    logic       standby;            // bit 6
    logic [3:0] remote_mask;        // bits 5..2, remote4..remote1
    logic       high_bias_select;   // bit 1
    logic       low_bias_select;    // bit 0
  } cfg_t;
  // live comparator and continuity conditions
  typedef struct packed {
    logic       local_high;
    logic       local_low;
    logic [3:0] remote_high;  // index 0 = remote1
    logic [3:0] remote_low;
    logic [3:0] remote_open;
  } cond_t;
  // diode bias level
  typedef enum logic [1:0] {
    BIAS_MED  = 2'h0,
    BIAS_LOW  = 2'h1,
    BIAS_HIGH = 2'h2
  } bias_t;
  // sensed strap pin level
  typedef enum logic [1:0] {
    STRAP_GND   = 2'h0,
    STRAP_FLOAT = 2'h1,
    STRAP_VCC   = 2'h2
  } strap_t;
  // conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    CONV_STBY = 3'b001,
    CONV_BUSY = 3'b010,
    CONV_REST = 3'b100
  } conv_state_t;
endpackage : thermo_pkg

// *** core/strap_decoder.sv ***
// address strap sampling and decoding
`timescale 1ns/1ps
`include "thermo_map.svh"
module strap_decoder
  import thermo_pkg::*;
(
  input  wire logic       clk,          // system clock
  input  wire logic       rst,          // sync reset, active high
  input  wire logic [1:0] addr_strap_a, // sensed level of strap a
  input  wire logic [1:0] addr_strap_b, // sensed level of strap b
  output logic      [6:0] slave_addr,   // latched address
  output logic            addr_valid    // address has been captured
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // first strap picks the base, second adds 0..2; unknown reads as floating
  function automatic logic [6:0] decode_addr(input logic [1:0] a, input logic [1:0] b);
    logic [6:0] base;
    logic [6:0] step;
    base = `ADDR_BASE_FLT;
    step = 7'h1;
    if (a == STRAP_GND) base = `ADDR_BASE_GND;
    else if (a == STRAP_VCC) base = `ADDR_BASE_VCC;
    if (b == STRAP_GND) step = 7'h0;
    else if (b == STRAP_VCC) step = 7'h2;
    return 7'(base + step);
  endfunction : decode_addr

  logic [3:0] sync1;      // first synchroniser stage
  logic [3:0] sync2;      // second stage, the only reader of sync1
  logic [1:0] settle;     // edges since reset release
  logic [1:0] next_settle;
  logic [6:0] next_slave_addr;
  logic       next_addr_valid;

  // ------------------------------------------------------------
  // capture once per power-on
  // ------------------------------------------------------------
  // straps are read only after the synchroniser has filled
  always_comb
  begin
    next_settle     = settle;
    next_slave_addr = slave_addr;
    next_addr_valid = addr_valid;
    if (!addr_valid)
    begin
      if (settle == `STRAP_SETTLE)
      begin
        next_slave_addr = decode_addr(sync2[3:2], sync2[1:0]);
        next_addr_valid = 1'b1;
      end
      else
        next_settle = 2'(settle + 2'h1);
    end
  end

  // registers; sync stages take no reset value from ports
  always_ff @(posedge clk)
  begin
    sync1 <= {addr_strap_a, addr_strap_b};
    sync2 <= sync1;
    if (rst)
    begin
      settle     <= 2'h0;
      slave_addr <= 7'h0;
      addr_valid <= 1'b0;
    end
    else
    begin
      settle     <= next_settle;
      slave_addr <= next_slave_addr;
      addr_valid <= next_addr_valid;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_addr_hold;
    @(posedge clk) disable iff (rst) addr_valid && $past(addr_valid) |-> $stable(slave_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed");
endmodule : strap_decoder

// *** core/thermo_status_config.sv ***
// status, configuration, identity and alert logic of the multichannel thermometer
`timescale 1ns/1ps
`include "thermo_map.svh"
module thermo_status_config
  import thermo_pkg::*;
#(
  parameter int         NUM_REMOTE  = 4,               // 4 or 2 remote channels
  parameter int         CONV_PERIOD = `CONV_PERIOD_CY, // cycles between conversion starts
  parameter logic [7:0] MAKER_ID    = 8'h5A,           // arbitrary value
  parameter logic [7:0] PART_ID     = 8'h21            // arbitrary value
)
(
  input  wire logic        clk,           // 10 MHz system clock
  input  wire logic        rst,           // sync power-on reset, active high
  input  wire logic        smb_clk_pin,   // bus clock pin, sampled
  input  wire logic        stop_seen,     // pulse: stop condition detected
  input  wire logic        reg_rd,        // pulse: register read
  input  wire logic        reg_wr,        // pulse: register write
  input  wire logic [7:0]  reg_cmd,       // command code of access
  input  wire logic [7:0]  wr_data,       // write byte
  output logic      [15:0] rd_data,       // read word, high byte zero
  output logic             rd_valid,      // pulse: rd_data valid
  input  wire logic [6:0]  bus_addr,      // address seen on the bus
  output logic             addr_match,    // bus_addr is ours
  input  wire logic        ara_ack,       // pulse: alert response answered
  output logic      [7:0]  ara_byte,      // byte sent on alert response
  input  wire logic [1:0]  addr_strap_a,  // strap a sensed level
  input  wire logic [1:0]  addr_strap_b,  // strap b sensed level
  input  wire cond_t       cond,          // live conditions
  input  wire logic        adc_done,      // pulse: conversion results ready
  output logic             conv_start,    // pulse: begin conversion
  output logic             conv_run,      // converter enabled
  output bias_t            bias,          // diode bias level
  output logic             alert_o,       // alert pin output value
  output logic             alert_oe       // alert pin driven low
);
  // ------------------------------------------------------------
  // parameter checks and declarations
  // ------------------------------------------------------------
  // refuse channel counts and periods the logic cannot serve
  if (NUM_REMOTE != 2 && NUM_REMOTE != 4) $error("NUM_REMOTE must be 2 or 4");
  if (CONV_PERIOD < 2) $error("CONV_PERIOD too small");
  localparam int CW = $clog2(CONV_PERIOD + 1);
  localparam logic [3:0] CH_EN = (NUM_REMOTE == 4) ? 4'hF : 4'h3; // present channels
  cfg_t        cfg;              // configuration byte
  cfg_t        next_cfg;
  logic        flag_local_high_flag, flag_local_low_flag, flag_open, flag_alarm; // sticky status one flags
  logic [7:0]  st2;              // status byte two
  logic        next_local_high_flag, next_local_low_flag, next_open, next_alarm;
  logic [7:0]  next_st2;
  logic        alert_latch;      // alert interrupt latch
  logic        next_alert;
  logic        alert_set;        // unmasked event this cycle
  logic [15:0] next_rd_data;
  logic        next_rd_valid;
  conv_state_t state;            // conversion sequencer
  conv_state_t next_state;
  logic [CW-1:0] cnt;            // period counter
  logic [CW-1:0] next_cnt;
  logic        smb_s1, smb_s2;   // bus clock synchroniser stages
  logic        smb_s3;           // delayed copy for edges
  logic        armed;            // stop seen, awaiting edge
  logic        next_armed;
  logic        refresh;          // first rising bus clock edge after stop
  logic        collide;          // status read meets result update
  logic [6:0]  slave_addr;       // strapped address
  logic        addr_valid;       // straps captured
  logic [7:0]  st1_view;         // status byte one as read
  logic [3:0]  r_high, r_low, r_open; // present remote conditions

  // pack remote low/high into status two order, remote1 low in bit 7
  function automatic logic [7:0] pack_st2(input logic [3:0] lo, input logic [3:0] hi);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      v[7 - 2*i] = lo[i];
      v[6 - 2*i] = hi[i];
    end
    return v;
  endfunction : pack_st2

  // ------------------------------------------------------------
  // address straps
  // ------------------------------------------------------------
  strap_decoder u_strap (
    .clk          (clk),
    .rst          (rst),
    .addr_strap_a (addr_strap_a),
    .addr_strap_b (addr_strap_b),
    .slave_addr   (slave_addr),
    .addr_valid   (addr_valid)
  );

  // own address or alert response while alerting
  assign addr_match = (addr_valid && bus_addr == slave_addr)
                    || (alert_latch && bus_addr == `ARA_ADDR);
  assign ara_byte   = {slave_addr, 1'b1};

  // ------------------------------------------------------------
  // conditions and bus clock edge
  // ------------------------------------------------------------
  assign r_high  = cond.remote_high & CH_EN;
  assign r_low   = cond.remote_low  & CH_EN;
  assign r_open  = cond.remote_open & CH_EN;
  assign refresh = armed && smb_s2 && !smb_s3;
  assign collide = adc_done || refresh;

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  // alert state is not an input here, so alerts never pause it
  always_comb
  begin
    next_state = state;
    next_cnt   = (cnt == '0) ? cnt : CW'(cnt - 1'b1);
    conv_start = 1'b0;
    case (state)
      CONV_STBY:
        if (!cfg.standby)
        begin
          next_state = CONV_BUSY;
          next_cnt   = CW'(CONV_PERIOD - 1);
          conv_start = 1'b1;
        end
      CONV_BUSY:
        if (adc_done) next_state = CONV_REST;
      CONV_REST:
        if (cnt == '0 && !cfg.standby)
        begin
          next_state = CONV_BUSY;
          next_cnt   = CW'(CONV_PERIOD - 1);
          conv_start = 1'b1;
        end
      default:
        next_state = CONV_STBY;
    endcase
    if (cfg.standby) next_state = CONV_STBY;
  end
  assign conv_run = !cfg.standby;

  // ------------------------------------------------------------
  // status flags and alert latch
  // ------------------------------------------------------------
  always_comb
  begin
    next_local_high_flag = flag_local_high_flag;
    next_local_low_flag  = flag_local_low_flag;
    next_open  = flag_open;
    next_alarm = flag_alarm;
    next_st2   = st2;
    next_alert = alert_latch;
    next_armed = armed;            // arm on stop, fire on next rising bus clock
    if (refresh) next_armed = 1'b0;
    if (stop_seen) next_armed = 1'b1;
    // read clears, collided reads leave flags alone
    if (reg_rd && !collide && reg_cmd == `CMD_STATUS1)
    begin
      next_local_high_flag = 1'b0;
      next_local_low_flag  = 1'b0;
      next_open  = 1'b0;
      next_alarm = 1'b0;
    end
    if (reg_rd && !collide && reg_cmd == `CMD_STATUS2)
      next_st2 = 8'h00;
    // sets after clears so a persisting condition wins
    if (adc_done || refresh)
    begin
      next_local_high_flag = next_local_high_flag | cond.local_high;
      next_local_low_flag  = next_local_low_flag  | cond.local_low;
      next_alarm = next_alarm | (|(r_high | r_low));
      next_st2   = next_st2   | pack_st2(r_low, r_high);
    end
    if (conv_start)
      next_open = next_open | (|r_open);
    if (ara_ack) next_alert = 1'b0;
    if (alert_set) next_alert = 1'b1;
  end

  // events from conversions only; status refresh never reaches the latch
  always_comb
  begin
    alert_set = 1'b0;
    if (adc_done)
      alert_set = cond.local_high || cond.local_low
                || (|((r_high | r_low) & ~cfg.remote_mask));
    if (conv_start && (|(r_open & ~cfg.remote_mask)))
      alert_set = 1'b1;
    if (cfg.global_alert_mask) alert_set = 1'b0;
  end

  assign alert_o  = 1'b0;
  assign alert_oe = alert_latch;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  assign st1_view = {state == CONV_BUSY, flag_local_high_flag, flag_local_low_flag, flag_open, flag_alarm, 3'h0};

  always_comb
  begin
    next_cfg      = cfg;
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    if (reg_wr && reg_cmd == `CMD_CFG_WR)
    begin
      next_cfg = cfg_t'(wr_data);
      next_cfg.remote_mask = wr_data[5:2] & CH_EN;
    end
    if (reg_rd)
    begin
      next_rd_valid = 1'b1;
      if (reg_cmd == `CMD_STATUS1)
        next_rd_data = {`BYTE_ZERO, collide ? {st1_view[7], `COLLIDE_LOW7} : st1_view};
      else if (reg_cmd == `CMD_STATUS2)
        next_rd_data = {`BYTE_ZERO, collide ? {st2[7], `COLLIDE_LOW7} : st2};
      else if (reg_cmd == `CMD_CFG_RD)
        next_rd_data = {`BYTE_ZERO, cfg};
      else if (reg_cmd == `CMD_MAKER)
        next_rd_data = {`BYTE_ZERO, MAKER_ID};
      else if (reg_cmd == `CMD_PART)
        next_rd_data = {`BYTE_ZERO, PART_ID};
      else
        next_rd_valid = 1'b0;
    end
  end

  // bias from config, high overrides low
  always_comb
  begin
    if (cfg.high_bias_select) bias = BIAS_HIGH;
    else if (cfg.low_bias_select) bias = BIAS_LOW;
    else bias = BIAS_MED;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    smb_s1 <= smb_clk_pin;
    smb_s2 <= smb_s1;
    smb_s3 <= smb_s2;
    if (rst)
    begin
      cfg         <= cfg_t'(`CFG_RESET);
      flag_local_high_flag  <= 1'b0;
      flag_local_low_flag   <= 1'b0;
      flag_open   <= 1'b0;
      flag_alarm  <= 1'b0;
      st2         <= 8'h00;
      alert_latch <= 1'b0;
      rd_data     <= 16'h0000;
      rd_valid    <= 1'b0;
      state       <= CONV_STBY;
      cnt         <= '0;
      armed       <= 1'b0;
    end
    else
    begin
      cfg         <= next_cfg;
      flag_local_high_flag  <= next_local_high_flag;
      flag_local_low_flag   <= next_local_low_flag;
      flag_open   <= next_open;
      flag_alarm  <= next_alarm;
      st2         <= next_st2;
      alert_latch <= next_alert;
      rd_data     <= next_rd_data;
      rd_valid    <= next_rd_valid;
      state       <= next_state;
      cnt         <= next_cnt;
      armed       <= next_armed;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ident;
    reg_rd && reg_cmd == `CMD_PART |=> rd_valid && rd_data == {8'h00, PART_ID};
  endproperty
  a_ident: assert property (p_ident) else $error("identity read wrong");
  property p_clear;
    reg_rd && reg_cmd == `CMD_STATUS2 && !collide |=> st2 == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("status two not cleared");
  property p_latch_free;
    !adc_done && !conv_start && !ara_ack |=> $stable(alert_latch);
  endproperty
  a_latch_free: assert property (p_latch_free) else $error("alert latch moved");
  property p_refresh;
    refresh && cond.local_high |=> flag_local_high_flag;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh lost local high");
  property p_open;
    $rose(flag_open) |-> $past(conv_start);
  endproperty
  a_open: assert property (p_open) else $error("open flag set off start");
  property p_gmask;
    cfg.global_alert_mask && !alert_latch |=> !alert_latch;
  endproperty
  a_gmask: assert property (p_gmask) else $error("masked alert raised");
  property p_stby;
    cfg.standby |-> !conv_start ##1 state == CONV_STBY;
  endproperty
  a_stby: assert property (p_stby) else $error("converting in standby");
  property p_release;
    ara_ack && !alert_set |=> !alert_latch;
  endproperty
  a_release: assert property (p_release) else $error("alert not released");
endmodule : thermo_status_config

// *** testbench/smbus_host_model.sv ***
// bus host stand-in: register accesses, bus clock frames and alert response
`timescale 1ns/1ps
module smbus_host_model
  import thermo_pkg::*;
(
  input  wire logic        clk,         // system clock
  input  wire logic [15:0] rd_data,     // read answer
  input  wire logic        rd_valid,    // read answer strobe
  output logic             smb_clk_pin, // bus clock, idles high
  output logic             stop_seen,   // stop condition pulse
  output logic             reg_rd,      // read request
  output logic             reg_wr,      // write request
  output logic      [7:0]  reg_cmd,     // command code
  output logic      [7:0]  wr_data,     // write byte
  output logic      [6:0]  bus_addr,    // address on the bus
  output logic             ara_ack      // alert response answered
);
  // ------------------------------------------------------------
  // idle levels at time zero
  // ------------------------------------------------------------
  initial
  begin
    smb_clk_pin = 1'b1;
    {stop_seen, reg_rd, reg_wr, ara_ack} = 4'h0;
    {reg_cmd, wr_data} = 16'h0000;
    bus_addr = 7'h00;
  end
  // one-cycle request raised and dropped at falling edges
  task automatic pulse_req(input logic wr, input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clk);
    reg_rd = ~wr;
    reg_wr = wr;
    reg_cmd = cmd;
    wr_data = data;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    wr_data = ~data;
  endtask : pulse_req
  // configuration or other write
  task automatic write(input logic [7:0] cmd, input logic [7:0] data);
    pulse_req(1'b1, cmd, data);
  endtask : write
  // read, answer taken one cycle after the request edge
  task automatic read(input logic [7:0] cmd, output logic ok);
    for (int t = 0; t < 3; t++)
    begin
      pulse_req(1'b0, cmd, 8'h00);
      ok = (rd_valid === 1'b1);
      // status with low seven ones is a collision: read again
      if (!(ok && (cmd == 8'h05 || cmd == 8'h06) && rd_data[6:0] === 7'h7F)) break;
    end
  endtask : read
  // nine bus clocks, stop, then one more rising clock edge
  task automatic frame();
    for (int b = 0; b < 10; b++)
    begin
      if (b == 9)
      begin
        stop_seen = 1'b1;
        @(negedge clk);
        stop_seen = 1'b0;
      end
      smb_clk_pin = 1'b0;
      repeat (4) @(negedge clk);
      smb_clk_pin = 1'b1;
      repeat (4) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask : frame
  // put an address on the bus, where it stays, and wait one cycle
  task automatic set_addr(input logic [6:0] a);
    @(negedge clk);
    bus_addr = a;
    @(negedge clk);
  endtask : set_addr
  // answered alert response
  task automatic alert_answer();
    @(negedge clk);
    ara_ack = 1'b1;
    @(negedge clk);
    ara_ack = 1'b0;
  endtask : alert_answer
endmodule : smbus_host_model

// *** testbench/thermometer_status_config_logic_tb.sv ***
// self-checking bench for the status/config block
`timescale 1ns/1ps
module thermometer_status_config_logic_tb
  import thermo_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int CONV_PERIOD = 50;  // shortened conversion spacing
  logic clk, rst, smb_clk_pin, stop_seen, reg_rd, reg_wr, rd_valid, addr_match, ara_ack;
  logic adc_done, conv_start, conv_run, alert_o, alert_oe, ok;
  logic [7:0]  reg_cmd, wr_data, ara_byte, v, seed;
  logic [15:0] rd_data;
  logic [6:0]  bus_addr;
  logic [1:0]  addr_strap_a, addr_strap_b;
  cond_t       cond;              // live conditions
  bias_t       bias;              // bias level seen
  logic [15:0] expect_q[$];       // expected read answers
  int          errors, samples_checked, conv_count, busy_left, c;
  logic [1:0]  strap_tab [3] = '{2'h0, 2'h1, 2'h2};
  logic [6:0]  addr_tab  [3] = '{7'h18, 7'h2A, 7'h4E};
  logic [7:0]  mask_tab  [5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
  // ------------------------------------------------------------
  // design and host
  // ------------------------------------------------------------
  thermo_status_config #(.CONV_PERIOD(CONV_PERIOD)) i_thermo_status_config (.clk, .rst, .smb_clk_pin, .stop_seen,
    .reg_rd, .reg_wr, .reg_cmd, .wr_data, .rd_data, .rd_valid, .bus_addr, .addr_match, .ara_ack, .ara_byte,
    .addr_strap_a, .addr_strap_b, .cond, .adc_done, .conv_start, .conv_run, .bias, .alert_o, .alert_oe);
  smbus_host_model i_smbus_host_model (.clk, .rd_data, .rd_valid, .smb_clk_pin, .stop_seen, .reg_rd, .reg_wr,
    .reg_cmd, .wr_data, .bus_addr, .ara_ack);
  // clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare
  task automatic conclude();
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic fail_wait(input string what);
    errors++;
    $display("[FAIL] %s expected done seen timeout", what);
    conclude();
  endtask : fail_wait
  // monitor: each read answer against the oldest note
  always @(posedge clk)
  begin
    if (conv_start === 1'b1) conv_count++;
    if (rd_valid === 1'b1)
      compare("rd_data", (expect_q.size() > 0) ? expect_q.pop_front() : 16'hDEAD, rd_data);
  end
  // converter stand-in: results ready six cycles after each start
  always @(negedge clk)
  begin
    adc_done <= 1'b0;
    if (conv_start === 1'b1) busy_left <= 6;
    else if (busy_left > 0)
    begin
      busy_left <= busy_left - 1;
      adc_done <= (busy_left == 1);
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    expect_q.push_back(exp);
    i_smbus_host_model.read(cmd, ok);
    if (ok !== 1'b1) fail_wait("rd_valid");
  endtask : rd
  task automatic wait_done();
    int n;
    n = 0;
    while (adc_done !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) fail_wait("adc_done");
    repeat (3) @(negedge clk);
  endtask : wait_done
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    adc_done = 1'b0;
    cond = '0;
    busy_left = 0;
    seed = 8'h3C;
    {addr_strap_a, addr_strap_b} = 4'h0;
    // straps decoded at reset, later changes ignored
    for (int k = 0; k < 3; k++)
    begin
      addr_strap_a = strap_tab[k];
      addr_strap_b = strap_tab[k];
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      addr_strap_a = strap_tab[(k + 1) % 3];
      i_smbus_host_model.set_addr(addr_tab[k]);
      compare("addr_match", 16'h0001, {15'h0, addr_match});
      compare("ara_byte", {8'h00, addr_tab[k], 1'b1}, {8'h00, ara_byte});
      i_smbus_host_model.set_addr(addr_tab[k] ^ 7'h01);
      compare("addr_match", 16'h0000, {15'h0, addr_match});
    end
    rd(8'hFE, 16'h005A);
    rd(8'hFF, 16'h0021);
    rd(8'h07, 16'h0000);
    compare("alert_oe", 16'h0000, {15'h0, alert_oe});
    // fixed bias cases, then random configuration bytes
    for (int i = 0; i < 7; i++)
    begin
      seed = lfsr_next(seed);
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'h03 : seed;
      i_smbus_host_model.write(8'h12, v);
      rd(8'h07, {8'h00, v});
      compare("bias", {14'h0, v[1] ? BIAS_HIGH : v[0] ? BIAS_LOW : BIAS_MED}, {14'h0, bias});
      compare("conv_run", {15'h0, ~v[6]}, {15'h0, conv_run});
    end
    // masked events never raise the alert
    for (int i = 0; i < 5; i++)
    begin
      i_smbus_host_model.write(8'h12, mask_tab[i]);
      if (i < 4) cond.remote_high[i] = 1'b1;
      else cond.local_high = 1'b1;
      wait_done();
      compare("alert_oe", 16'h0000, {15'h0, alert_oe});
      cond = '0;
    end
    i_smbus_host_model.write(8'h12, 8'h00);
    cond.remote_high[0] = 1'b1;
    wait_done();
    cond = '0;
    compare("alert_oe", 16'h0001, {15'h0, alert_oe});
    // conversions keep running while the alert stands
    repeat (CONV_PERIOD) @(negedge clk);
    c = conv_count;
    repeat (4 * CONV_PERIOD) @(negedge clk);
    compare("conversions", 16'd4, 16'(conv_count - c));
    compare("alert_oe", 16'h0001, {15'h0, alert_oe});
    // standby before reading status
    i_smbus_host_model.write(8'h12, 8'h40);
    repeat (10) @(negedge clk);
    c = conv_count;
    repeat (2 * CONV_PERIOD) @(negedge clk);
    compare("standby", 16'd0, 16'(conv_count - c));
    rd(8'h05, 16'h0048);
    rd(8'h06, 16'h0055);
    rd(8'h05, 16'h0000);
    rd(8'h06, 16'h0000);
    compare("alert_oe", 16'h0001, {15'h0, alert_oe});
    // refresh after stop: threshold yes, open fault no
    cond.local_high = 1'b1;
    cond.remote_open[1] = 1'b1;
    i_smbus_host_model.frame();
    rd(8'h05, 16'h0040);
    cond = '0;
    i_smbus_host_model.set_addr(7'h0C);
    compare("addr_match", 16'h0001, {15'h0, addr_match});
    i_smbus_host_model.alert_answer();
    compare("alert_oe", 16'h0000, {15'h0, alert_oe});
    i_smbus_host_model.set_addr(7'h0C);
    compare("addr_match", 16'h0000, {15'h0, addr_match});
    rd(8'h05, 16'h0000);
    // open fault taken at the next conversion start
    cond.remote_open[1] = 1'b1;
    i_smbus_host_model.write(8'h12, 8'h00);
    wait_done();
    i_smbus_host_model.write(8'h12, 8'h40);
    cond = '0;
    rd(8'h05, 16'h0010);
    compare("alert_oe", 16'h0001, {15'h0, alert_oe});
    compare("alert_o", 16'h0000, {15'h0, alert_o});
    conclude();
  end
endmodule : thermometer_status_config_logic_tb
